/* File: design/ppos_pkg.sv */
// Constants for the port pin output select block.
// Assumes an 8-bit register write/read port decoded from the serial interface.
package ppos_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register addresses within the common register area
   localparam logic [7:0] PPOS_ADDR_PAGE   = 8'h80;
   localparam logic [7:0] PPOS_ADDR_SRC01  = 8'h81;
   localparam logic [7:0] PPOS_ADDR_SRC23  = 8'h82;
   localparam logic [7:0] PPOS_ADDR_INVDRV = 8'h83;
   localparam logic [7:0] PPOS_ADDR_POL01  = 8'h84;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] PPOS_RST_PAGE    = 8'h00;
   localparam logic [7:0] PPOS_RST_SRC01   = 8'h50;
   localparam logic [7:0] PPOS_RST_SRC23   = 8'h12;
   localparam logic [7:0] PPOS_RST_INVDRV  = 8'h00;
   localparam logic [7:0] PPOS_RST_POL01   = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PPOS_SRC_LO_LSB  = 0;
   localparam int PPOS_SRC_HI_LSB  = 4;
   localparam int PPOS_INV_LSB     = 0;
   localparam int PPOS_DRV_LSB     = 4;
   localparam int PPOS_POL_P0_LSB  = 0;
   localparam int PPOS_POL_P1_LSB  = 4;
   localparam int PPOS_PAGE_W      = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Source selector codes
   localparam logic [3:0] PPOS_SRC_CLK     = 4'h0;
   localparam logic [3:0] PPOS_SRC_RXACT   = 4'h1;
   localparam logic [3:0] PPOS_SRC_INT     = 4'h2;
   localparam logic [3:0] PPOS_SRC_LOW     = 4'h3;
   localparam logic [3:0] PPOS_SRC_HIGH    = 4'h4;
   localparam logic [3:0] PPOS_SRC_SLICED  = 4'h5;
   localparam logic [3:0] PPOS_SRC_MFIL    = 4'h6;
   localparam logic [3:0] PPOS_SRC_CHDATA  = 4'h8;
   localparam logic [3:0] PPOS_SRC_CHSTR   = 4'h9;
   localparam logic [3:0] PPOS_SRC_DECDATA = 4'ha;
   localparam logic [3:0] PPOS_SRC_DECSTR  = 4'hb;

endpackage : ppos_pkg

/* File: design/ppos_pin_mux.sv */
// One port pin: source select, receive-active polarity, inversion, output flop.
// Assumes all source signals are synchronous to ref_clk_in.
`timescale 1ns/100ps
module ppos_pin_mux
   import ppos_pkg::*;
#(
   parameter bit CLK_ALLOWED = 1'b1
) (
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   // Settings
   input  wire logic [3:0] src_sel_in,
   input  wire logic       rx_pol_in,
   input  wire logic       invert_in,
   // Sources
   input  wire logic       clk_out_in,
   input  wire logic       rx_active_in,
   input  wire logic       interrupt_low_active_in,
   input  wire logic       sliced_data_in,
   input  wire logic       matched_filter_data_in,
   input  wire logic       chip_data_in,
   input  wire logic       chip_strobe_in,
   input  wire logic       decoded_data_in,
   input  wire logic       decoded_strobe_in,
   // Pin
   output logic            pin_out
);

   typedef struct packed {
      logic pin;
   } ppos_pin_state_t;

   ppos_pin_state_t s_r;
   ppos_pin_state_t s_nxt;
   logic            raw;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      case (src_sel_in)
         PPOS_SRC_CLK:     raw = CLK_ALLOWED ? clk_out_in : 1'b0;
         PPOS_SRC_RXACT:   raw = rx_pol_in ? rx_active_in : ~rx_active_in;
         PPOS_SRC_INT:     raw = interrupt_low_active_in;
         PPOS_SRC_LOW:     raw = 1'b0;
         PPOS_SRC_HIGH:    raw = 1'b1;
         PPOS_SRC_SLICED:  raw = sliced_data_in;
         PPOS_SRC_MFIL:    raw = matched_filter_data_in;
         PPOS_SRC_CHDATA:  raw = chip_data_in;
         PPOS_SRC_CHSTR:   raw = chip_strobe_in;
         PPOS_SRC_DECDATA: raw = decoded_data_in;
         PPOS_SRC_DECSTR:  raw = decoded_strobe_in;
         // Unused codes park raw low so the pin holds its invert level, never junk
         default:          raw = 1'b0;
      endcase
      s_nxt     = s_r;
      s_nxt.pin = raw ^ invert_in;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         s_r.pin <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pin_out = s_r.pin;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence sel_is(logic [3:0] c);
      src_sel_in == c;
   endsequence

   a_low_code: assert property (sel_is(PPOS_SRC_LOW) |=> pin_out == $past(invert_in))
      else $error("low code gave wrong pin level");
   a_high_code: assert property (sel_is(PPOS_SRC_HIGH) |=> pin_out == !$past(invert_in))
      else $error("high code gave wrong pin level");
   a_rx_polarity: assert property (sel_is(PPOS_SRC_RXACT) ##0 !invert_in
         |=> pin_out == ($past(rx_active_in) == $past(rx_pol_in)))
      else $error("receive-active polarity wrong");
   a_invert_data: assert property (sel_is(PPOS_SRC_SLICED)
         |=> pin_out == ($past(sliced_data_in) ^ $past(invert_in)))
      else $error("sliced data inversion wrong");
   a_no_clk_pin: assert property ((sel_is(PPOS_SRC_CLK) and (!CLK_ALLOWED))
         |=> pin_out == $past(invert_in))
      else $error("clock appeared on a pin without clock out");
   a_decoded_strobe: assert property (sel_is(PPOS_SRC_DECSTR) ##0 !invert_in
         |=> pin_out == $past(decoded_strobe_in))
      else $error("decoded strobe not routed");

endmodule : ppos_pin_mux

/* File: design/ppos_port_pins.sv */
// Port pin output select: settings registers and four pin multiplexers.
// Assumes the serial interface delivers decoded byte writes and read strobes,
// and that the receiver reports the configuration it is running.
`timescale 1ns/100ps
module ppos_port_pins
   import ppos_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       reset_n_in,
   // Register access
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic [7:0]      reg_rdata_out,
   output logic            reg_rvalid_out,
   // Receiver status
   input  wire logic [1:0] active_config_in,
   // Pin sources
   input  wire logic       clk_out_in,
   input  wire logic       rx_active_in,
   input  wire logic       interrupt_low_active_in,
   input  wire logic       sliced_data_in,
   input  wire logic       matched_filter_data_in,
   input  wire logic       chip_data_in,
   input  wire logic       chip_strobe_in,
   input  wire logic       decoded_data_in,
   input  wire logic       decoded_strobe_in,
   // Pads
   output logic [3:0]      port_pin_out,
   output logic [3:0]      strong_drive_out,
   output logic [1:0]      register_page_select_out
);

   typedef struct packed {
      logic [1:0] page;
      logic [7:0] src01;
      logic [7:0] src23;
      logic [7:0] invdrv;
      logic [7:0] pol01;
      logic [7:0] rdata;
      logic       rvalid;
   } ppos_regs_t;

   ppos_regs_t s_r;
   ppos_regs_t s_nxt;
   logic [3:0] sel [4];
   logic [3:0] pol;
   logic [7:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and reads
   always_comb begin
      s_nxt        = s_r;
      s_nxt.rvalid = reg_rd_in;
      if (reg_wr_in) begin
         case (reg_addr_in)
            PPOS_ADDR_PAGE:   s_nxt.page   = reg_wdata_in[PPOS_PAGE_W-1:0];
            PPOS_ADDR_SRC01:  s_nxt.src01  = reg_wdata_in;
            PPOS_ADDR_SRC23:  s_nxt.src23  = reg_wdata_in;
            PPOS_ADDR_INVDRV: s_nxt.invdrv = reg_wdata_in;
            PPOS_ADDR_POL01:  s_nxt.pol01  = reg_wdata_in;
            default:          s_nxt.page   = s_r.page;
         endcase
      end
      case (reg_addr_in)
         PPOS_ADDR_PAGE:   rd_mux = {6'h00, s_r.page};
         PPOS_ADDR_SRC01:  rd_mux = s_r.src01;
         PPOS_ADDR_SRC23:  rd_mux = s_r.src23;
         PPOS_ADDR_INVDRV: rd_mux = s_r.invdrv;
         PPOS_ADDR_POL01:  rd_mux = s_r.pol01;
         default:          rd_mux = 8'h00;
      endcase
      s_nxt.rdata = reg_rd_in ? rd_mux : s_r.rdata;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!reset_n_in) begin
         s_r.page   <= PPOS_RST_PAGE[PPOS_PAGE_W-1:0];
         s_r.src01  <= PPOS_RST_SRC01;
         s_r.src23  <= PPOS_RST_SRC23;
         s_r.invdrv <= PPOS_RST_INVDRV;
         s_r.pol01  <= PPOS_RST_POL01;
         s_r.rdata  <= 8'h00;
         s_r.rvalid <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata_out            = s_r.rdata;
   assign reg_rvalid_out           = s_r.rvalid;
   assign register_page_select_out = s_r.page;
   assign strong_drive_out         = s_r.invdrv[PPOS_DRV_LSB +: 4];

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin selection; pins 2 and 3 keep active-high receive-active
   assign sel[0] = s_r.src01[PPOS_SRC_LO_LSB +: 4];
   assign sel[1] = s_r.src01[PPOS_SRC_HI_LSB +: 4];
   assign sel[2] = s_r.src23[PPOS_SRC_LO_LSB +: 4];
   assign sel[3] = s_r.src23[PPOS_SRC_HI_LSB +: 4];
   // Running configuration, not the page being addressed, picks polarity
   assign pol[0] = s_r.pol01[PPOS_POL_P0_LSB + int'(active_config_in)];
   assign pol[1] = s_r.pol01[PPOS_POL_P1_LSB + int'(active_config_in)];
   assign pol[2] = 1'b1;
   assign pol[3] = 1'b1;

   for (genvar i = 0; i < 4; i++) begin : g_pin
      ppos_pin_mux #(
         .CLK_ALLOWED (i != 3)
      ) u_pin (
         .ref_clk_in              (ref_clk_in),
         .reset_n_in              (reset_n_in),
         .src_sel_in              (sel[i]),
         .rx_pol_in               (pol[i]),
         .invert_in               (s_r.invdrv[PPOS_INV_LSB + i]),
         .clk_out_in              (clk_out_in),
         .rx_active_in            (rx_active_in),
         .interrupt_low_active_in (interrupt_low_active_in),
         .sliced_data_in          (sliced_data_in),
         .matched_filter_data_in  (matched_filter_data_in),
         .chip_data_in            (chip_data_in),
         .chip_strobe_in          (chip_strobe_in),
         .decoded_data_in         (decoded_data_in),
         .decoded_strobe_in       (decoded_strobe_in),
         .pin_out                 (port_pin_out[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence wr_to(logic [7:0] a);
      reg_wr_in && reg_addr_in == a;
   endsequence

   a_src01_write: assert property (wr_to(PPOS_ADDR_SRC01) |=> s_r.src01 == $past(reg_wdata_in))
      else $error("pin 0/1 selector not written");
   a_drive_write: assert property (wr_to(PPOS_ADDR_INVDRV)
         |=> strong_drive_out == $past(reg_wdata_in[7:4]))
      else $error("strong drive not applied");
   a_page_write: assert property (wr_to(PPOS_ADDR_PAGE)
         |=> register_page_select_out == $past(reg_wdata_in[1:0]))
      else $error("page select not written");
   a_unmapped_read: assert property (reg_rd_in && !(reg_addr_in inside {[PPOS_ADDR_PAGE:PPOS_ADDR_POL01]})
         |=> reg_rvalid_out && reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_pin0_rx_pol: assert property (sel[0] == PPOS_SRC_RXACT && !s_r.invdrv[0]
         |=> port_pin_out[0] == ($past(rx_active_in) == $past(s_r.pol01[int'(active_config_in)])))
      else $error("pin 0 receive-active polarity wrong");
   a_pin2_interrupt: assert property (sel[2] == PPOS_SRC_INT
         |=> port_pin_out[2] == ($past(interrupt_low_active_in) ^ $past(s_r.invdrv[2])))
      else $error("pin 2 interrupt not routed");
   a_read_back: assert property (reg_rd_in && reg_addr_in == PPOS_ADDR_POL01
         |=> reg_rvalid_out && reg_rdata_out == $past(s_r.pol01))
      else $error("polarity register read wrong");
   a_pin1_rx_pol: assert property (sel[1] == PPOS_SRC_RXACT && !s_r.invdrv[1]
         |=> port_pin_out[1] == ($past(rx_active_in) == $past(s_r.pol01[4 + int'(active_config_in)])))
      else $error("pin 1 receive-active polarity wrong");
   a_reset_value: assert property ($rose(reset_n_in) |-> s_r.src01 == PPOS_RST_SRC01
         && s_r.src23 == PPOS_RST_SRC23 && s_r.pol01 == PPOS_RST_POL01)
      else $error("register reset values wrong");

endmodule : ppos_port_pins

/* File: tb/ppos_source_model.sv */
// Far-side source model: nine receiver signals from a free-running shift register.
// Assumes the bench maps the bits onto the source ports of the block.
`timescale 1ns/100ps
module ppos_source_model (
   // Clock
   input  wire logic       ref_clk_in,
   // Sources, bit order clk, rx, int, sliced, mfil, chd, chs, decd, decs
   output logic [8:0]      src_out
);
   logic [15:0] lfsr_r;

   initial lfsr_r = 16'hace1;
   // Pattern moves every cycle, so a stale sample never passes for a fresh one
   always @(posedge ref_clk_in) begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
   end
   assign src_out = lfsr_r[8:0];
endmodule : ppos_source_model

/* File: tb/ppos_port_pins_tb.sv */
// Self-checking bench for the port pin output select block.
// Assumes the design's package and the source model are compiled first.
`timescale 1ns/100ps
module ppos_port_pins_tb import ppos_pkg::*;;
   logic       ref_clk_in;
   logic       reset_n_in;
   logic       reg_wr_in;
   logic       reg_rd_in;
   logic [7:0] reg_addr_in;
   logic [7:0] reg_wdata_in;
   logic [7:0] reg_rdata_out;
   logic       reg_rvalid_out;
   logic [1:0] active_config_in;
   logic [1:0] register_page_select_out;
   logic [3:0] port_pin_out;
   logic [3:0] strong_drive_out;
   logic [8:0] src;
   logic [7:0] sh [0:4];
   logic [7:0] rd_q [$];
   int         miscompares = 0;
   int         checks = 0;
   int         seed = 56;

   ////////////////////////////////////////////////////////////////////////////
   ppos_source_model ppos_source_model_inst (.ref_clk_in(ref_clk_in), .src_out(src));
   ppos_port_pins ppos_port_pins_inst (
      .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .active_config_in(active_config_in),
      .clk_out_in(src[0]), .rx_active_in(src[1]), .interrupt_low_active_in(src[2]), .sliced_data_in(src[3]),
      .matched_filter_data_in(src[4]), .chip_data_in(src[5]), .chip_strobe_in(src[6]),
      .decoded_data_in(src[7]), .decoded_strobe_in(src[8]), .port_pin_out(port_pin_out),
      .strong_drive_out(strong_drive_out), .register_page_select_out(register_page_select_out));

   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check8

   task automatic finish_test();
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr_in    <= 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      rd_q.push_back((a inside {[8'h80:8'h84]}) ? sh[a - 8'h80] : 8'h00);
      @(posedge ref_clk_in);
      reg_rd_in   <= 1'b0;
   endtask : rd

   function automatic logic pin_exp(int n, logic [3:0] sel, logic pol, logic inv, logic [8:0] s);
      logic v;
      case (sel)
         4'h0:    v = (n == 3) ? 1'b0 : s[0];
         4'h1:    v = pol ? s[1] : ~s[1];
         4'h2:    v = s[2];
         4'h4:    v = 1'b1;
         4'h5:    v = s[3];
         4'h6:    v = s[4];
         4'h8:    v = s[5];
         4'h9:    v = s[6];
         4'ha:    v = s[7];
         4'hb:    v = s[8];
         default: v = 1'b0;
      endcase
      return v ^ inv;
   endfunction : pin_exp

   ////////////////////////////////////////////////////////////////////////////
   // Pins use settings before this edge's write; registers take the write here
   always @(posedge ref_clk_in) begin
      logic [3:0] e;
      for (int n = 0; n < 4; n++) begin
         e[n] = pin_exp(n, (n < 2) ? sh[1][4*n +: 4] : sh[2][4*(n-2) +: 4],
                        (n == 0) ? sh[4][active_config_in] : (n == 1) ? sh[4][4 + active_config_in] : 1'b1,
                        sh[3][n], src);
      end
      if (reset_n_in !== 1'b1) begin
         e = 4'h0;
         sh = '{PPOS_RST_PAGE, PPOS_RST_SRC01, PPOS_RST_SRC23, PPOS_RST_INVDRV, PPOS_RST_POL01};
      end else if (reg_wr_in && reg_addr_in inside {[8'h80:8'h84]}) begin
         sh[reg_addr_in - 8'h80] = (reg_addr_in == PPOS_ADDR_PAGE) ? {6'h00, reg_wdata_in[1:0]} : reg_wdata_in;
      end
      #1;
      check8("port_pin_out", {4'h0, e}, {4'h0, port_pin_out});
      // Pad and page outputs follow the register at the write edge itself
      check8("strong_drive_out", {4'h0, sh[3][7:4]}, {4'h0, strong_drive_out});
      check8("register_page_select_out", sh[0], {6'h00, register_page_select_out});
      if (reg_rvalid_out !== 1'b0) begin
         if (rd_q.size() == 0) check8("reg_rvalid_out", 8'h00, 8'h01);
         else check8("reg_rdata_out", rd_q.pop_front(), reg_rdata_out);
      end
   end

   always @(posedge ref_clk_in) active_config_in <= 2'($random(seed));

   initial begin
      reset_n_in       = 1'b0;
      reg_wr_in        = 1'b0;
      reg_rd_in        = 1'b0;
      reg_addr_in      = 8'h00;
      reg_wdata_in     = 8'h00;
      active_config_in = 2'h0;
      repeat (4) @(posedge ref_clk_in);
      reset_n_in <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         for (int a = 8'h80; a <= 8'h85; a++) rd(8'(a));
         wr(8'h85, 8'h5a);
         for (int c = 0; c < 12; c++) begin
            if (c != 7) begin
               wr(PPOS_ADDR_SRC01, {4'(c), 4'(c)});
               // Second pass puts code 0 on pin three, which must hold its invert level, not the clock
               wr(PPOS_ADDR_SRC23, {(c == 0 && k == 0) ? 4'h1 : 4'(c), 4'(c)});
               wr(PPOS_ADDR_INVDRV, 8'($random(seed)));
               wr(PPOS_ADDR_POL01, 8'($random(seed)));
               wr(PPOS_ADDR_PAGE, {6'h00, 2'(c)});
               rd(PPOS_ADDR_PAGE);
               rd(PPOS_ADDR_INVDRV);
               repeat (8) @(posedge ref_clk_in);
            end
         end
         // Reset in mid-run, then the reset values once more
         @(posedge ref_clk_in);
         reset_n_in <= 1'b0;
         repeat (2) @(posedge ref_clk_in);
         reset_n_in <= 1'b1;
      end
      repeat (4) @(posedge ref_clk_in);
      if (rd_q.size() != 0) miscompares++;
      finish_test();
   end
endmodule : ppos_port_pins_tb
